// *** vac_autocal.sv ***
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "vac_params.svh"
module vac_autocal import vac_pkg::*; #(
	parameter int CW = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [4:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [23:0] reg_rdata,
	input wire logic osc_in,
	input wire logic lock_in,
	output logic vtune_hold,
	output logic link_en,
	output logic link_data,
	output logic link_strobe,
	output logic [18:0] div_int,
	output logic [23:0] div_frac,
	output logic cal_busy
);
	// ---------------------------------------------------------------
	// reset release and input synchronisers
	// ---------------------------------------------------------------
	logic rst_meta_q, rst_n_q;
	logic osc_s1_q, osc_s2_q, osc_s3_q, lock_s1_q, lock_s2_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			{osc_s1_q, osc_s2_q, osc_s3_q} <= 3'h0;
			{lock_s1_q, lock_s2_q} <= 2'h0;
		end else begin
			osc_s1_q <= osc_in;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
			lock_s1_q <= lock_in;
			lock_s2_q <= lock_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [13:0] refdiv_q;
	logic [18:0] int_q;
	logic [23:0] frac_q;
	logic [15:0] oscw_q;
	logic frac_mode_q, relock_en_q;
	logic [14:0] calcfg_q;
	logic [4:0] code_q;
	logic wr_int, wr_frac, wr_oscw, cal_dis;
	vac_state_type st_q;

	assign wr_int = reg_wr && reg_addr == `VAC_A_INT;
	assign wr_frac = reg_wr && reg_addr == `VAC_A_FRAC;
	assign wr_oscw = reg_wr && reg_addr == `VAC_A_OSCW;
	assign cal_dis = calcfg_q[`VAC_B_CALDIS];

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			refdiv_q <= `VAC_RST_REFDIV;
			int_q <= 19'h00000;
			frac_q <= 24'h000000;
			oscw_q <= 16'h0000;
			frac_mode_q <= 1'b0;
			relock_en_q <= 1'b0;
			calcfg_q <= `VAC_RST_CALCFG;
		end else if (reg_wr) begin
			case (reg_addr)
				`VAC_A_REFDIV: refdiv_q <= reg_wdata[13:0];
				`VAC_A_INT: int_q <= reg_wdata[18:0];
				`VAC_A_FRAC: frac_q <= reg_wdata;
				`VAC_A_OSCW: oscw_q <= reg_wdata[15:0];
				`VAC_A_MODE: frac_mode_q <= reg_wdata[`VAC_B_FRACMODE];
				`VAC_A_LOCK: relock_en_q <= reg_wdata[`VAC_B_RELOCK];
				`VAC_A_CALCFG: calcfg_q <= reg_wdata[14:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= 24'h000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`VAC_A_REFDIV: reg_rdata <= {10'h000, refdiv_q};
				`VAC_A_INT: reg_rdata <= {5'h00, int_q};
				`VAC_A_FRAC: reg_rdata <= frac_q;
				`VAC_A_OSCW: reg_rdata <= {8'h00, oscw_q};
				`VAC_A_MODE: reg_rdata <= 24'(frac_mode_q) << `VAC_B_FRACMODE;
				`VAC_A_LOCK: reg_rdata <= 24'(relock_en_q) << `VAC_B_RELOCK;
				`VAC_A_CALCFG: reg_rdata <= {9'h000, calcfg_q};
				// switch byte: payload top bits, reserved one, code
				`VAC_A_STATUS: reg_rdata <= {15'h0000, cal_busy, oscw_q[`VAC_F_PAYHI],
					1'b1, code_q};
				default: reg_rdata <= 24'h000000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// calibration tick divider
	// ---------------------------------------------------------------
	logic [4:0] div_cnt_q, div_mask;
	logic tick;

	always_comb begin
		case (calcfg_q[`VAC_F_MSEL])
			2'h0: div_mask = 5'h00;
			2'h1: div_mask = 5'h03;
			2'h2: div_mask = 5'h0F;
			default: div_mask = 5'h1F;
		endcase
	end
	assign tick = (div_cnt_q & div_mask) == div_mask;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_cnt_q <= 5'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// serial transfer engine
	// ---------------------------------------------------------------
	logic [15:0] sh_q;
	logic [4:0] tx_cnt_q, tx_len_q;
	logic tx_busy_q, tx_start, tx_done, man_pend_q;
	logic [15:0] tx_word;
	logic [4:0] tx_len;
	logic [4:0] trial_q, best_q;

	assign tx_done = tx_busy_q && tick && tx_cnt_q == tx_len_q - 5'h01;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			man_pend_q <= 1'b0;
		end else if (wr_oscw) begin
			man_pend_q <= 1'b1; // write wins over clear
		end else if (tx_start && st_q == ST_IDLE) begin
			man_pend_q <= 1'b0;
		end
	end

	always_comb begin
		tx_start = 1'b0;
		tx_word = oscw_q;
		tx_len = `VAC_MAN_XFER;
		if (st_q == ST_IDLE) begin
			tx_start = man_pend_q && !tx_busy_q;
		end else if ((st_q == ST_SEND || st_q == ST_FINAL) && !tx_busy_q) begin
			tx_start = 1'b1;
			tx_len = `VAC_CAL_XFER;
			// payload carries code; id and index stay as written
			tx_word = {oscw_q[`VAC_F_PAYHI], 1'b1, st_q == ST_FINAL ? best_q : trial_q,
				oscw_q[`VAC_B_PAYLO], oscw_q[`VAC_F_RIDX], oscw_q[`VAC_F_ID]};
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_busy_q <= 1'b0;
			tx_cnt_q <= 5'h00;
			tx_len_q <= 5'h00;
			sh_q <= 16'h0000;
		end else if (tx_start) begin
			tx_busy_q <= 1'b1;
			tx_cnt_q <= 5'h00;
			tx_len_q <= tx_len;
			sh_q <= tx_word;
		end else if (tx_busy_q && tick) begin
			tx_cnt_q <= tx_cnt_q + 5'h01;
			if (tx_cnt_q < `VAC_WORD_BITS) begin
				sh_q <= {sh_q[14:0], 1'b0};
			end
			if (tx_done) begin
				tx_busy_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			link_en <= 1'b0;
			link_data <= 1'b0;
			link_strobe <= 1'b0;
		end else begin
			link_strobe <= tx_busy_q && tick && tx_cnt_q < `VAC_WORD_BITS;
			if (tx_busy_q && tick && tx_cnt_q < `VAC_WORD_BITS) begin
				link_en <= 1'b1;
				link_data <= sh_q[15]; // msb first
			end else if (tx_busy_q && tick) begin
				link_en <= 1'b0;
				link_data <= 1'b0;
			end else if (!tx_busy_q) begin
				link_en <= 1'b0;
				link_data <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// expected count and trigger
	// ---------------------------------------------------------------
	logic [49:0] nsh;
	logic [CW-1:0] expect_cnt, cnt_q, err, best_err_q;
	logic [20:0] win_q, win_len;
	logic [8:0] wait_q, wait_len;
	logic cal_pend_q, trig, relock_trig, armed_q, seen_lock_q, relock_run_q;
	logic extra_q, keep_bit, was_relock_q;
	logic [2:0] bit_q;

	assign nsh = {7'h00, int_q, frac_q} << calcfg_q[`VAC_F_NEXP];
	assign expect_cnt = CW'(nsh[49:`VAC_FRAC_BITS]);
	assign win_len = 21'(refdiv_q == 14'h0000 ? 14'h0001 : refdiv_q)
		<< calcfg_q[`VAC_F_NEXP];
	assign wait_len = 9'(calcfg_q[`VAC_F_WAITK]) * `VAC_WAIT_BLOCK;
	// fractional mode triggers on fraction, integer mode on integer
	assign trig = !cal_dis && (frac_mode_q ? wr_frac : wr_int);
	assign relock_trig = relock_en_q && armed_q && seen_lock_q && !lock_s2_q;
	assign err = cnt_q > expect_cnt ? cnt_q - expect_cnt : expect_cnt - cnt_q;
	assign keep_bit = cnt_q > expect_cnt; // oscillator fast: more capacitance

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cal_pend_q <= 1'b0;
		end else if (trig || relock_trig) begin
			cal_pend_q <= 1'b1;
		end else if (st_q == ST_IDLE && !man_pend_q && !tx_busy_q) begin
			cal_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			armed_q <= 1'b0;
			seen_lock_q <= 1'b0;
			relock_run_q <= 1'b0;
		end else begin
			if (relock_trig) begin
				armed_q <= 1'b0; // only one attempt
				relock_run_q <= 1'b1;
			end else if (trig) begin
				relock_run_q <= 1'b0;
			end else if (st_q == ST_LOAD && !was_relock_q) begin
				armed_q <= 1'b1;
			end
			if (st_q != ST_IDLE) begin
				seen_lock_q <= 1'b0;
			end else if (lock_s2_q) begin
				seen_lock_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// calibration sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= ST_IDLE;
			wait_q <= 9'h000;
			win_q <= 21'h000000;
			cnt_q <= '0;
			best_err_q <= '0;
			bit_q <= 3'h0;
			trial_q <= 5'h00;
			best_q <= 5'h00;
			extra_q <= 1'b0;
			was_relock_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (cal_pend_q && !man_pend_q && !tx_busy_q) begin
						st_q <= ST_WAIT;
						wait_q <= 9'h000;
						bit_q <= `VAC_TOP_BIT;
						trial_q <= 5'h01 << `VAC_TOP_BIT;
						best_err_q <= '1;
						extra_q <= 1'b0;
						was_relock_q <= relock_run_q;
					end
				end
				ST_WAIT: begin
					if (wait_q >= wait_len) begin
						st_q <= ST_SEND;
					end else if (tick) begin
						wait_q <= wait_q + 9'h001;
					end
				end
				ST_SEND: begin
					if (tx_done) begin
						st_q <= ST_MEAS;
						win_q <= 21'h000000;
						cnt_q <= '0;
					end
				end
				ST_MEAS: begin
					if (osc_s2_q && !osc_s3_q) begin
						cnt_q <= cnt_q + CW'(1);
					end
					if (win_q == win_len - 21'h000001) begin
						st_q <= ST_JUDGE;
					end else begin
						win_q <= win_q + 21'h000001;
					end
				end
				ST_JUDGE: begin
					if (err < best_err_q) begin
						best_err_q <= err;
						best_q <= trial_q;
					end
					if (extra_q) begin
						st_q <= ST_FINAL;
					end else begin
						if (!keep_bit) begin
							trial_q[bit_q] <= 1'b0;
						end
						if (bit_q != 3'h0) begin
							bit_q <= bit_q - 3'h1;
							trial_q[bit_q - 3'h1] <= 1'b1;
							st_q <= ST_SEND;
						end else if (!keep_bit) begin
							extra_q <= 1'b1;
							st_q <= ST_SEND;
						end else begin
							st_q <= ST_FINAL;
						end
					end
				end
				ST_FINAL: begin
					if (tx_done) begin
						st_q <= ST_LOAD;
					end
				end
				ST_LOAD: st_q <= ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// outputs: divider load, code, hold
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_int <= 19'h00000;
			div_frac <= 24'h000000;
			code_q <= 5'h00;
			vtune_hold <= 1'b0;
			cal_busy <= 1'b0;
		end else begin
			if (st_q == ST_LOAD) begin
				div_int <= int_q;
				div_frac <= frac_q;
				code_q <= best_q;
			end else if (cal_dis && (wr_int || wr_frac)) begin
				div_int <= wr_int ? reg_wdata[18:0] : int_q;
				div_frac <= wr_frac ? reg_wdata : frac_q;
			end
			vtune_hold <= st_q != ST_IDLE && st_q != ST_LOAD;
			cal_busy <= cal_pend_q || (st_q != ST_IDLE && st_q != ST_LOAD);
		end
	end
endmodule : vac_autocal

// *** vac_autocal_asserts.sv ***
`timescale 1ns/100ps
module vac_autocal_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reg_rd,
	input wire logic [23:0] reg_rdata,
	input wire logic vtune_hold,
	input wire logic link_en,
	input wire logic link_data,
	input wire logic link_strobe,
	input wire logic cal_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ---------------------------------------------
	// bits seen in the current link frame
	// ---------------------------------------------
	logic [4:0] nbit_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nbit_q <= 5'h00;
		end else if (!link_en) begin
			nbit_q <= 5'h00;
		end else if (link_strobe) begin
			nbit_q <= nbit_q + 5'h01;
		end
	end
	rst_quiet_a: assert property (disable iff (1'b0) !nrst |-> !vtune_hold && !link_en && !cal_busy)
		else $error("outputs active in reset");
	hold_busy_a: assert property (vtune_hold |-> cal_busy)
		else $error("tuning held while idle");
	idle_release_a: assert property ($fell(cal_busy) |-> !vtune_hold)
		else $error("hold outlives calibration");
	frame_bits_a: assert property ($fell(link_en) |-> nbit_q == 5'h10)
		else $error("link frame not 16 bits");
	strobe_frame_a: assert property (link_strobe |-> link_en)
		else $error("strobe outside frame");
	first_bit_a: assert property ($rose(link_en) |-> link_strobe)
		else $error("frame opens without bit");
	bit_hold_a: assert property (link_en && !link_strobe |-> $stable(link_data))
		else $error("link bit moved mid slot");
	rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without read");
	cover property ($fell(vtune_hold));
	cover property ($fell(link_en) && !cal_busy);
	cover property ($rose(cal_busy) && !vtune_hold);
endmodule : vac_autocal_asserts

bind vac_autocal vac_autocal_asserts u_chk (.clk(clk), .nrst(nrst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .vtune_hold(vtune_hold), .link_en(link_en), .link_data(link_data),
	.link_strobe(link_strobe), .cal_busy(cal_busy));

// *** vac_osc_model.sv ***
`timescale 1ns/100ps
module vac_osc_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic fast,
	input wire logic link_en,
	input wire logic link_data,
	input wire logic link_strobe,
	output logic osc_out,
	output logic [15:0] word_q,
	output logic [3:0] nxfer_q,
	output logic [7:0] gap_q
);
	logic [15:0] sh_q;
	logic [7:0] cnt_q;
	logic en_q;
	// free running output, still when slow
	always @(negedge clk or negedge nrst) begin
		if (!nrst) begin
			osc_out <= 1'b0;
		end else begin
			osc_out <= fast ? ~osc_out : 1'b0;
		end
	end
	// link receiver, msb first, counts frames and bit spacing
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{sh_q, word_q, nxfer_q, gap_q, cnt_q, en_q} <= '0;
		end else begin
			en_q <= link_en;
			cnt_q <= link_strobe ? 8'h00 : cnt_q + 8'h01;
			if (link_strobe) begin
				sh_q <= {sh_q[14:0], link_data};
				gap_q <= cnt_q + 8'h01;
			end
			if (en_q && !link_en) begin
				word_q <= sh_q;
				nxfer_q <= nxfer_q + 4'h1;
			end
		end
	end
endmodule : vac_osc_model

// *** vac_params.svh ***
`ifndef VAC_PARAMS_SVH
`define VAC_PARAMS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define VAC_A_REFDIV 5'h02
`define VAC_A_INT 5'h03
`define VAC_A_FRAC 5'h04
`define VAC_A_OSCW 5'h05
`define VAC_A_MODE 5'h06
`define VAC_A_LOCK 5'h07
`define VAC_A_CALCFG 5'h0A
`define VAC_A_STATUS 5'h10
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define VAC_B_FRACMODE 11
`define VAC_B_RELOCK 13
`define VAC_B_CALDIS 11
`define VAC_F_NEXP 2:0
`define VAC_F_WAITK 7:6
`define VAC_F_MSEL 14:13
`define VAC_F_ID 2:0
`define VAC_F_RIDX 6:3
`define VAC_F_PAY 15:7
`define VAC_F_PAYHI 15:14
`define VAC_B_PAYLO 7
`define VAC_B_BUSY 8
// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
`define VAC_RST_REFDIV 14'h0001
`define VAC_RST_CALCFG 15'h0000
`define VAC_WAIT_BLOCK 9'h080
`define VAC_CAL_XFER 5'h14
`define VAC_MAN_XFER 5'h10
`define VAC_WORD_BITS 5'h10
`define VAC_FRAC_BITS 24
`define VAC_TOP_BIT 3'h4
`endif

// *** vac_pkg.sv ***
package vac_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SEND,
		ST_MEAS,
		ST_JUDGE,
		ST_FINAL,
		ST_LOAD
	} vac_state_type;
endpackage : vac_pkg

// *** vco_subband_autocal_fsm_tb.sv ***
`timescale 1ns/100ps
module vco_subband_autocal_fsm_tb;
	logic clk = 1'b0;
	logic nrst;
	logic [4:0] reg_addr = 5'h00;
	logic [23:0] reg_wdata = 24'h000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic lock_in = 1'b0;
	logic fast = 1'b0;
	logic [23:0] reg_rdata, div_frac;
	logic [18:0] div_int;
	logic osc, vtune_hold, link_en, link_data, link_strobe, cal_busy;
	logic [15:0] lw;
	logic [3:0] nx;
	logic [7:0] gap;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	vac_autocal u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_in(osc), .lock_in(lock_in),
		.vtune_hold(vtune_hold), .link_en(link_en), .link_data(link_data),
		.link_strobe(link_strobe), .div_int(div_int), .div_frac(div_frac), .cal_busy(cal_busy));
	vac_osc_model u_osc (.clk(clk), .nrst(nrst), .fast(fast), .link_en(link_en),
		.link_data(link_data), .link_strobe(link_strobe), .osc_out(osc), .word_q(lw),
		.nxfer_q(nx), .gap_q(gap));
	// ---------------------------------------------
	// bus tasks and expectations
	// ---------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [23:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask : rd
	task automatic wait_idle();
		repeat (40) @(posedge clk);
		while (cal_busy !== 1'b0 || link_en !== 1'b0) begin
			@(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask : wait_idle
	function automatic logic [23:0] cfg(input logic dis, input logic [1:0] k, input logic [1:0] ms);
		return {9'h000, ms, 1'b0, dis, 3'h0, k, 3'h0, 3'h5};
	endfunction : cfg
	function automatic logic [23:0] exp_xfer(input logic f);
		return f ? 24'h000006 : 24'h000007;
	endfunction : exp_xfer
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			$display("[FAIL] %0t timeout", $time);
			report_and_stop();
		end
	end
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		logic [23:0] fr, v;
		logic [15:0] w;
		logic [3:0] n0, dn;
		logic f;
		logic [1:0] k, ms;
		int d, t;
		nrst <= 1'b0;
		void'($urandom(32'hBAD62AE2));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rd(5'h10, v);
		chk(v, 24'h000020, "status reset");
		rd(5'h1F, v);
		chk(v, 24'h000000, "unmapped");
		$display("reset checks done");
		fr = 24'h000000;
		for (int i = 0; i < 6; i++) begin
			f = (i < 2) ? (i == 0) : 1'($urandom % 2);
			fr = (i == 1) ? fr : 24'($urandom) & 24'h1FFFFF;
			w = 16'($urandom);
			k = 2'($urandom % 2);
			ms = 2'(1 + $urandom % 3);
			t = 1 << ((ms == 2'h1) ? 2 : (ms == 2'h2) ? 4 : 5);
			fast <= f;
			wr(5'h06, {12'h000, 1'(i != 3), 11'h000});
			wr(5'h0A, cfg(1'b0, k, ms));
			wr(5'h05, {8'h00, w});
			wait_idle();
			n0 = nx;
			v = div_frac;
			wr(5'h04, fr);
			if (i == 3) begin
				wr(5'h03, 24'h000000);
			end
			chk(div_frac, v, "frac early");
			d = 2;
			while (link_en !== 1'b1) begin
				@(posedge clk);
				d++;
			end
			chk(24'(d + 2 >= k * 128 * t && d < (k * 128 + 3) * t + 6), 24'h1, "wait");
			wait_idle();
			dn = nx - n0;
			chk(24'(dn), exp_xfer(f), "transfers");
			chk({21'h0, lw[15:13]}, {21'h0, w[15:14], 1'b1}, "word top");
			chk({16'h0, lw[7:0]}, {16'h0, w[7:0]}, "word low");
			chk(24'(gap), 24'(t), "tick");
			chk(div_frac, fr, "frac loaded");
			rd(5'h10, v);
			chk(v, {16'h0000, lw[15:8]}, "status");
			$display("cal run %0d done", i);
		end
		wr(5'h0A, cfg(1'b1, 2'h0, 2'h1));
		w = 16'($urandom);
		n0 = nx;
		wr(5'h05, {8'h00, w});
		wait_idle();
		dn = nx - n0;
		chk(24'(dn), 24'h000001, "one frame");
		chk({8'h00, lw}, {8'h00, w}, "manual word");
		fr = 24'($urandom);
		wr(5'h04, fr);
		chk(div_frac, fr, "frac direct");
		v = 24'($urandom) & 24'h07FFFF;
		wr(5'h03, v);
		chk({5'h00, div_int}, v, "int direct");
		$display("manual mode done");
		wr(5'h0A, cfg(1'b0, 2'h0, 2'h1));
		wr(5'h07, 24'h002000);
		wr(5'h04, fr);
		wait_idle();
		for (int j = 0; j < 2; j++) begin
			lock_in <= 1'b1;
			repeat (8) @(posedge clk);
			lock_in <= 1'b0;
			repeat (8) @(posedge clk);
			chk(24'(cal_busy), (j == 0) ? 24'h1 : 24'h0, "relock");
			wait_idle();
		end
		$display("relock done");
		report_and_stop();
	end
endmodule : vco_subband_autocal_fsm_tb
